//--- bench/i2cbpc_master_sva.sv
// Purpose: port checks of the i2c master
// Assumes: one mclk domain
// Notes: bound to every master instance
`timescale 1ns/10ps
module i2cbpc_master_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // axi4-lite
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // i2c pins
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // pads may only pull low
  pin_zero_a: assert property (!sclOut && !sdaOut)
    else $error("pin data not zero");
  // the high half counts from the seen rise, so a stretch delays it
  scl_wait_a: assert property ($rose(sclOe) |-> $past(sclIn) && $past(sclIn, 8))
    else $error("scl pulled low too early");
  start_idle_a: assert property ($rose(sdaOe) && !sclOe |-> $past(sdaIn) && $past(sclIn))
    else $error("start while bus busy");
  sda_edge_a: assert property ($changed(sdaOe) && !sclOe && !$past(sclOe) |-> sclIn)
    else $error("sda moved outside start or stop");
  bresp_ok_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("bad write response");
  rresp_ok_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("bad read response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule
bind i2cbpc_master i2cbpc_master_sva i_i2cbpc_master_sva (
  .mclk, .sys_rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
  .s_axi_rvalid, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe);

//--- bench/i2cbpc_master_tb_top.sv
// Purpose: self-checking bench of the i2c master
// Assumes: pull-ups on both lines, HALF_CYC shortened
// Notes: a rival master is one extra sda pull
`timescale 1ns/10ps
`include "i2cbpc_cfg.svh"
module i2cbpc_master_tb_top;
  localparam logic [6:0] SLV = 7'h2a;
  logic mclk = 0;
  logic sys_rst = 1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe, sclLowS, sdaLowS;
  logic rivalSda = 0, stretch = 0;
  logic [7:0] rdByte = 8'h96, lastByte;
  int fails = 0, total_checks = 0, cyc = 0;
  // open-drain lines with pull-ups
  assign sclIn = ~(sclOe | sclLowS);
  assign sdaIn = ~(sdaOe | sdaLowS | rivalSda);
  i2cbpc_master #(.HALF_CYC(8)) i_i2cbpc_master (
    .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sclIn, .sclOut, .sclOe, .sdaIn,
    .sdaOut, .sdaOe);
  i2cbpc_slave_model #(.ADDR(SLV)) i_i2cbpc_slave_model (
    .scl(sclIn), .sda(sdaIn), .rdByte, .stretch, .sdaLow(sdaLowS),
    .sclLow(sclLowS), .lastByte);
  always #2.5 mclk = ~mclk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // ready is looked at on the falling edge, settled, and acted on at the rise
  task automatic axiWr(logic [3:0] a, logic [31:0] d);
    logic aw, w, b;
    @(posedge mclk);
    b = 1'b0;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!b) begin
      @(negedge mclk);
      {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
  endtask
  task automatic axiRd(logic [3:0] a, output logic [31:0] d);
    logic ar, r;
    @(posedge mclk);
    r = 1'b0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!r) begin
      @(negedge mclk);
      {ar, r, d} = {s_axi_arready, s_axi_rvalid, s_axi_rdata};
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
  endtask
  // issue a command then poll until the byte is over
  task automatic cmd(logic [31:0] c, output logic [31:0] s);
    if (c != 0) axiWr(`I2CBPC_OFF_CTRL, 32'h100 | c);
    s = 32'h2;
    while (s[1]) axiRd(`I2CBPC_OFF_STAT, s);
  endtask
  task automatic t_write();
    logic [31:0] s;
    stretch <= 1;
    axiWr(`I2CBPC_OFF_TXD, {24'h0, SLV, 1'b0});
    cmd(32'h9, s);
    chk("addr ack", 1, s[3]);
    axiWr(`I2CBPC_OFF_TXD, 32'ha5);
    cmd(32'ha, s);
    chk("data ack", 1, s[3]);
    chk("slave byte", 32'ha5, lastByte);
    chk("idle lines", 3, {sclIn, sdaIn});
    stretch <= 0;
    $display("t_write done");
  endtask
  task automatic t_comb();
    logic [31:0] s;
    axiWr(`I2CBPC_OFF_TXD, {24'h0, SLV, 1'b0});
    cmd(32'h9, s);
    axiWr(`I2CBPC_OFF_TXD, {24'h0, SLV, 1'b1});
    cmd(32'h9, s);
    chk("restart ack", 1, s[3]);
    cmd(32'h4, s);
    axiRd(`I2CBPC_OFF_RXD, s);
    chk("rx byte 1", 32'h96, s[7:0]);
    // the model has already put out bit 7, so keep it equal
    rdByte <= 8'hbc;
    cmd(32'h16, s);
    axiRd(`I2CBPC_OFF_RXD, s);
    chk("rx byte 2", 32'hbc, s[7:0]);
    chk("idle after read", 3, {sclIn, sdaIn});
    $display("t_comb done");
  endtask
  task automatic t_nack();
    logic [31:0] s;
    axiWr(`I2CBPC_OFF_TXD, 32'h22);
    cmd(32'hb, s);
    chk("absent slave", 0, s[3]);
    $display("t_nack done");
  endtask
  // a rival start holds the bus; our start must wait for its stop
  task automatic t_busy();
    logic [31:0] s;
    rivalSda <= 1;
    axiWr(`I2CBPC_OFF_TXD, {24'h0, SLV, 1'b0});
    axiWr(`I2CBPC_OFF_CTRL, 32'h10b);
    repeat (60) @(posedge mclk);
    chk("held off", 0, {sclOe, sdaOe});
    rivalSda <= 0;
    cmd(0, s);
    chk("late ack", 1, s[3]);
    $display("t_busy done");
  endtask
  // rival sends a zero where we send a one and wins
  task automatic t_arb();
    logic [31:0] s;
    axiWr(`I2CBPC_OFF_TXD, 32'haa);
    axiWr(`I2CBPC_OFF_CTRL, 32'h109);
    wait (sclOe === 1'b1);
    @(posedge mclk);
    rivalSda <= 1;
    // the loser stays busy until the rival's stop, so poll done
    s = 32'h0;
    while (!s[2]) axiRd(`I2CBPC_OFF_STAT, s);
    chk("arb lost", 1, s[4]);
    chk("pins freed", 0, {sclOe, sdaOe});
    rivalSda <= 0;
    axiRd(`I2CBPC_OFF_STAT, s);
    chk("lost cleared", 0, s[4]);
    $display("t_arb done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      $display("[FAIL] timeout expected 0 seen 1");
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    axiWr(`I2CBPC_OFF_CTRL, 32'h100);
    t_write();
    t_comb();
    t_nack();
    t_busy();
    t_arb();
    wrap_up();
  end
endmodule

//--- bench/i2cbpc_slave_model.sv
// Purpose: behavioural i2c slave facing the master
// Assumes: bench resolves the open-drain lines
// Notes: acks its address, sends rdByte on reads
`timescale 1ns/10ps
module i2cbpc_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // behaviour
  input wire logic [7:0] rdByte,
  input wire logic stretch,
  // pulls and captured byte
  output logic sdaLow = 1'b0,
  output logic sclLow = 1'b0,
  output logic [7:0] lastByte = 8'h00
);
  int bitN = 0;
  logic [7:0] sh = 8'h00;
  logic sel = 0, rd = 0, adr = 0, mAck = 0;
  // start or restart opens an address phase
  always @(negedge sda) if (scl) begin
    bitN = 0;
    adr = 1;
    sel = 0;
    sdaLow = 0;
  end
  // stop drops the selection
  always @(posedge sda) if (scl) sel = 0;
  // sample on the rising edge
  always @(posedge scl) begin
    if (bitN < 8) sh = {sh[6:0], sda};
    else mAck = ~sda;
    bitN++;
  end
  // drive only while scl is low; a slow slave stretches after the ack
  always @(negedge scl) begin
    if (bitN == 9) begin
      bitN = 0;
      adr = 0;
      sdaLow = 0;
      if (stretch) begin
        sclLow = 1;
        #200 sclLow = 0;
      end
    end
    if (bitN == 8) begin
      if (adr) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
        mAck = 1;
      end
      if (sel && !rd && !adr) lastByte = sh;
      sdaLow = sel && !(rd && !adr);
    end else if (sel && rd && !adr && mAck) begin
      sdaLow = ~rdByte[7 - bitN];
    end
  end
endmodule

//--- common/i2cbpc_cfg.svh
// Purpose: timing counts and register offsets of the i2c bus master
// Assumes: 200 MHz mclk
// Notes: offsets are byte addresses on the axi4-lite slave
`ifndef I2CBPC_CFG_SVH
`define I2CBPC_CFG_SVH
`define I2CBPC_CLK_MHZ 200
`define I2CBPC_HALF_NS 2500
`define I2CBPC_HALF_CYC ((`I2CBPC_HALF_NS * `I2CBPC_CLK_MHZ) / 1000)
`define I2CBPC_OFF_CTRL 4'h0
`define I2CBPC_OFF_TXD 4'h4
`define I2CBPC_OFF_STAT 4'h8
`define I2CBPC_OFF_RXD 4'hc
`define I2CBPC_CTRL_START 0
`define I2CBPC_CTRL_STOP 1
`define I2CBPC_CTRL_READ 2
`define I2CBPC_CTRL_WRITE 3
`define I2CBPC_CTRL_NACK 4
`define I2CBPC_CTRL_EN 8
`endif

//--- common/i2cbpc_pkg.sv
// Purpose: types of the i2c bus master
// Assumes: nothing
// Notes: state of the master is one packed struct
package i2cbpc_pkg;
  typedef enum logic [3:0] {
    IDLE, STA1, STA2, BITL, BITH, STO1, STO2, STO3, RSTA, LOST
  } i2cbpc_state_type;

  typedef enum logic [1:0] {
    OP_NONE, OP_WRITE, OP_READ
  } i2cbpc_op_type;

  typedef struct packed {
    i2cbpc_state_type st;
    i2cbpc_op_type op;
    logic [15:0] cnt;
    logic [3:0] bitN;
    logic [8:0] shift;
    logic sdaLow;
    logic sclLow;
    logic busBusy;
    logic sdaPrev;
    logic sclPrev;
    logic [1:0] sdaSync;
    logic [1:0] sclSync;
    logic enable;
    logic pendStart;
    logic pendStop;
    logic pendNack;
    logic [7:0] txData;
    logic [7:0] rxData;
    logic ackSeen;
    logic arbLost;
    logic done;
    logic awPend;
    logic [3:0] awAddr;
    logic wPend;
    logic [31:0] wData;
    logic bValid;
    logic rValid;
    logic [31:0] rData;
  } i2cbpc_regs_type;
endpackage

//--- hw/i2cbpc_master.sv
// Purpose: i2c bus master commanded over axi4-lite
// Assumes: open-drain scl/sda resolved outside; pins are async inputs
// Notes: output pin data is always zero, only the enables toggle
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "i2cbpc_cfg.svh"
module i2cbpc_master #(
  parameter int HALF_CYC = `I2CBPC_HALF_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // axi4-lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // i2c pins, split open-drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  i2cbpc_pkg::i2cbpc_regs_type q_r, q_nxt;
  logic sda, scl, cntDone, busy, wrGo;
  logic [3:0] rdA;

  assign sda = q_r.sdaSync[1];
  assign scl = q_r.sclSync[1];
  assign cntDone = (q_r.cnt == 16'h0000);
  // parked with scl low between bytes counts as ready for a command
  assign busy = ((q_r.st != i2cbpc_pkg::IDLE)
    && (q_r.st != i2cbpc_pkg::RSTA)) || q_r.pendStart
    || (q_r.op != i2cbpc_pkg::OP_NONE) || q_r.pendStop;

  // pins only pull low or release
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = q_r.sclLow & q_r.enable;
  assign sdaOe = q_r.sdaLow & q_r.enable;

  // axi handshakes; one write and one read outstanding
  assign s_axi_awready = !q_r.awPend && !q_r.bValid;
  assign s_axi_wready = !q_r.wPend && !q_r.bValid;
  assign s_axi_bvalid = q_r.bValid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !q_r.rValid;
  assign s_axi_rvalid = q_r.rValid;
  assign s_axi_rdata = q_r.rData;
  assign s_axi_rresp = 2'h0;
  assign wrGo = (q_r.awPend || (s_axi_awvalid && s_axi_awready))
    && (q_r.wPend || (s_axi_wvalid && s_axi_wready));

  // next-state logic for bus, axi and byte engine
  always_comb begin
    q_nxt = q_r;
    rdA = s_axi_araddr;
    // two-stage synchronisers, first stage read only by second
    q_nxt.sdaSync = {q_r.sdaSync[0], sdaIn};
    q_nxt.sclSync = {q_r.sclSync[0], sclIn};
    q_nxt.sdaPrev = sda;
    q_nxt.sclPrev = scl;
    // bus monitor: start sets busy, stop clears it
    if (scl && q_r.sclPrev && q_r.sdaPrev && !sda) begin
      q_nxt.busBusy = 1'b1;
    end
    if (scl && q_r.sclPrev && !q_r.sdaPrev && sda) begin
      q_nxt.busBusy = 1'b0;
    end
    if (!q_r.cnt[15] && !cntDone) begin
      q_nxt.cnt = q_r.cnt - 16'h0001;
    end
    // write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      q_nxt.awPend = 1'b1;
      q_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      q_nxt.wPend = 1'b1;
      q_nxt.wData = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      q_nxt.bValid = 1'b0;
    end
    if (wrGo && !q_r.bValid) begin
      q_nxt.awPend = 1'b0;
      q_nxt.wPend = 1'b0;
      q_nxt.bValid = 1'b1;
      // unmapped writes are accepted and ignored; busy writes only update the enable bit
      if (q_nxt.awAddr == `I2CBPC_OFF_CTRL && s_axi_wstrb[0]) begin
        q_nxt.enable = s_axi_wstrb[1] ?
          q_nxt.wData[`I2CBPC_CTRL_EN] : q_r.enable;
        if (!busy && q_nxt.enable) begin
          q_nxt.pendStart = q_nxt.wData[`I2CBPC_CTRL_START];
          q_nxt.pendStop = q_nxt.wData[`I2CBPC_CTRL_STOP];
          q_nxt.pendNack = q_nxt.wData[`I2CBPC_CTRL_NACK];
          q_nxt.done = 1'b0;
          if (q_nxt.wData[`I2CBPC_CTRL_WRITE]) begin
            q_nxt.op = i2cbpc_pkg::OP_WRITE;
          end else if (q_nxt.wData[`I2CBPC_CTRL_READ]) begin
            q_nxt.op = i2cbpc_pkg::OP_READ;
          end
        end
      end
      if (q_nxt.awAddr == `I2CBPC_OFF_TXD && s_axi_wstrb[0] && !busy) begin
        q_nxt.txData = q_nxt.wData[7:0];
      end
    end
    // read channel, answered one cycle after address
    if (s_axi_rvalid && s_axi_rready) begin
      q_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      q_nxt.rValid = 1'b1;
      case (rdA)
        `I2CBPC_OFF_CTRL: q_nxt.rData = {23'h000000, q_r.enable, 8'h00};
        `I2CBPC_OFF_TXD: q_nxt.rData = {24'h000000, q_r.txData};
        `I2CBPC_OFF_STAT: q_nxt.rData = {26'h0000000, q_r.busBusy,
          q_r.arbLost, q_r.ackSeen, q_r.done, busy, 1'b0};
        `I2CBPC_OFF_RXD: q_nxt.rData = {24'h000000, q_r.rxData};
        default: q_nxt.rData = 32'h00000000;
      endcase
      if (rdA == `I2CBPC_OFF_STAT) begin
        q_nxt.arbLost = 1'b0; // cleared on read
      end
    end
    // bit engine, one state per half scl period
    case (q_r.st)
      i2cbpc_pkg::IDLE: begin
        q_nxt.sclLow = 1'b0;
        q_nxt.sdaLow = 1'b0;
        if (q_r.pendStart && !q_r.busBusy && sda && scl) begin
          q_nxt.pendStart = 1'b0;
          q_nxt.sdaLow = 1'b1;
          q_nxt.cnt = 16'(HALF_CYC);
          q_nxt.st = i2cbpc_pkg::STA1;
        end else if (q_r.pendStart && q_r.busBusy) begin
          q_nxt.st = i2cbpc_pkg::IDLE; // hold off until bus idle
        end else if (!q_r.pendStart && q_r.op != i2cbpc_pkg::OP_NONE) begin
          q_nxt.op = i2cbpc_pkg::OP_NONE; // nothing to do without a start
          q_nxt.pendStop = 1'b0;
          q_nxt.done = 1'b1;
        end
      end
      i2cbpc_pkg::STA1: begin
        if (cntDone) begin
          q_nxt.sclLow = 1'b1;
          q_nxt.cnt = 16'(HALF_CYC);
          q_nxt.st = i2cbpc_pkg::STA2;
          q_nxt.busBusy = 1'b1;
        end
      end
      i2cbpc_pkg::STA2: begin
        // load the byte; ninth bit is ack, driven or released
        q_nxt.bitN = 4'h0;
        if (q_r.op == i2cbpc_pkg::OP_WRITE) begin
          q_nxt.shift = {q_r.txData, 1'b1};
        end else begin
          q_nxt.shift = {8'hff, q_r.pendNack};
        end
        if (cntDone) begin
          q_nxt.st = i2cbpc_pkg::BITL;
          q_nxt.cnt = 16'(HALF_CYC);
        end
      end
      i2cbpc_pkg::BITL: begin
        // scl low: set sda now so it never moves while scl high
        q_nxt.sdaLow = !q_r.shift[8];
        if (cntDone) begin
          q_nxt.sclLow = 1'b0;
          q_nxt.st = i2cbpc_pkg::BITH;
          q_nxt.cnt = 16'hffff;
        end
      end
      i2cbpc_pkg::BITH: begin
        // high count starts only once scl is seen high
        if (q_r.cnt[15] && scl) begin
          q_nxt.cnt = 16'(HALF_CYC);
        end else if (!q_r.cnt[15] && !q_r.sclPrev && scl) begin
          q_nxt.cnt = q_r.cnt;
        end
        if (q_r.cnt == 16'(HALF_CYC) && !q_r.sclPrev) begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end
        if (!q_r.cnt[15] && q_r.cnt == 16'(HALF_CYC - 1)) begin
          // sample on the rise; high released bit read back
          if (q_r.shift[8] && !sda && (q_r.bitN != 4'h8
              || q_r.op == i2cbpc_pkg::OP_READ)
              && !(q_r.op == i2cbpc_pkg::OP_READ && q_r.bitN != 4'h8)) begin
            q_nxt.arbLost = 1'b1;
            q_nxt.sdaLow = 1'b0;
            q_nxt.sclLow = 1'b0;
            q_nxt.op = i2cbpc_pkg::OP_NONE;
            q_nxt.pendStop = 1'b0;
            q_nxt.done = 1'b1;
            q_nxt.st = i2cbpc_pkg::LOST;
          end
          if (q_r.bitN == 4'h8) begin
            q_nxt.ackSeen = !sda;
          end else begin
            q_nxt.rxData = {q_r.rxData[6:0], sda};
          end
          q_nxt.shift = {q_r.shift[7:0], 1'b1};
        end
        if (!q_r.cnt[15] && cntDone && q_r.st == q_nxt.st) begin
          q_nxt.sclLow = 1'b1;
          q_nxt.cnt = 16'(HALF_CYC);
          if (q_r.bitN == 4'h8) begin
            q_nxt.done = 1'b1;
            q_nxt.op = i2cbpc_pkg::OP_NONE;
            q_nxt.st = q_r.pendStop ? i2cbpc_pkg::STO1 : i2cbpc_pkg::RSTA;
          end else begin
            q_nxt.bitN = q_r.bitN + 4'h1;
            q_nxt.st = i2cbpc_pkg::BITL;
          end
        end
      end
      i2cbpc_pkg::RSTA: begin
        // hold scl low, wait for next command from software
        q_nxt.sdaLow = 1'b0;
        if (q_r.op != i2cbpc_pkg::OP_NONE) begin
          q_nxt.done = 1'b0;
          if (q_r.pendStart) begin
            // repeated start: release, raise scl, then pull sda
            q_nxt.pendStart = 1'b0;
            q_nxt.sclLow = 1'b0;
            if (scl && cntDone) begin
              q_nxt.sdaLow = 1'b1;
              q_nxt.cnt = 16'(HALF_CYC);
              q_nxt.st = i2cbpc_pkg::STA1;
            end else begin
              q_nxt.pendStart = 1'b1;
            end
          end else begin
            q_nxt.st = i2cbpc_pkg::STA2;
          end
        end else if (q_r.pendStop) begin
          // a full low half before scl rises, so sda never moves with it
          q_nxt.cnt = 16'(HALF_CYC);
          q_nxt.st = i2cbpc_pkg::STO1;
        end
      end
      i2cbpc_pkg::STO1: begin
        // stop follows the ninth bit when reading too: sda low at scl low
        q_nxt.sdaLow = 1'b1;
        q_nxt.pendStop = 1'b0;
        if (cntDone) begin
          q_nxt.sclLow = 1'b0;
          q_nxt.st = i2cbpc_pkg::STO2;
        end
      end
      i2cbpc_pkg::STO2: begin
        if (scl) begin
          q_nxt.cnt = 16'(HALF_CYC);
          q_nxt.st = i2cbpc_pkg::STO3;
        end
      end
      i2cbpc_pkg::STO3: begin
        if (cntDone) begin
          q_nxt.sdaLow = 1'b0;
          q_nxt.st = i2cbpc_pkg::IDLE;
        end
      end
      i2cbpc_pkg::LOST: begin
        // released; wait for the winner's stop before retry
        q_nxt.sclLow = 1'b0;
        q_nxt.sdaLow = 1'b0;
        if (!q_r.busBusy) begin
          q_nxt.st = i2cbpc_pkg::IDLE;
        end
      end
      default: q_nxt.st = i2cbpc_pkg::IDLE;
    endcase
    if (!q_r.enable) begin
      q_nxt.st = i2cbpc_pkg::IDLE;
      q_nxt.sclLow = 1'b0;
      q_nxt.sdaLow = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule
